/* File: rtl/cwbm_defs.svh */
// Purpose: Constants for the cascaded receiver chain.
// Assumes: 50 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef CWBM_DEFS_SVH
`define CWBM_DEFS_SVH

// Number of receivers in the chain, one per byte of the word.
`define CWBM_NUM_RX     4
// Width of one received byte.
`define CWBM_BYTE_W     8
// Clock period in ns.
`define CWBM_CLK_NS     20
// Shortest time for one encoded byte on the link, in ns.
`define CWBM_BYTE_NS    100
// Least byte time in clock cycles, rounded up.
`define CWBM_BYTE_CYC   ((`CWBM_BYTE_NS + `CWBM_CLK_NS - 1) / `CWBM_CLK_NS)
// Width of the byte spacing counter.
`define CWBM_GAP_W      3

`endif

/* File: rtl/cwbm_pkg.sv */
// Purpose: Types shared by the cascaded receiver chain.
// Assumes: cwbm_defs.svh holds the numeric constants.
// Notes:   A decoded symbol travels as one packed struct.
`include "cwbm_defs.svh"

package cwbm_pkg;

	// One decoded symbol from the shared serial input.
	typedef struct packed {
		logic                     valid; // Symbol present this cycle.
		logic                     sync;  // Symbol is a sync character.
		logic [`CWBM_BYTE_W-1:0]  data;  // Data byte when not a sync.
	} cwbm_sym_t;

endpackage

/* File: rtl/cwbm_rx_slice.sv */
// Purpose: One receiver of the cascade: catches its byte and presents it.
// Assumes: Symbols come from logic on the same clock, already rate limited.
// Notes:   Input latch, decoder latch and output latch give two cycles to strobe.
`timescale 1ns/1ps

module cwbm_rx_slice (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire cwbm_pkg::cwbm_sym_t     sym,
	input  wire logic                    take_next_in,
	input  wire logic                    xfer,
	output logic                         capture_done_out,
	output logic [`CWBM_BYTE_W-1:0]      byte_out,
	output logic                         rx_data_valid_strobe,
	output logic                         capture_pulse
);
	import cwbm_pkg::*;

	logic                      armed_ff;   // Ready to catch one byte.
	logic                      take_d_ff;  // Last take-next level, for edges.
	logic [`CWBM_BYTE_W-1:0]   in_ff;      // Input latch.
	logic [`CWBM_BYTE_W-1:0]   dec_ff;     // Decoder latch.
	logic                      stage_ff;   // Decoder latch just loaded.
	logic                      nxt_armed;  // Next arming state.
	logic                      nxt_done;   // Next capture-done level.
	wire                       take_rise;  // Take-next went low then high.
	wire                       sync_seen;  // Accepted sync symbol.

	assign sync_seen     = sym.valid && sym.sync;
	assign take_rise     = take_next_in && !take_d_ff;
	// Only a non-sync byte with take-next high and still armed is caught.
	assign capture_pulse = take_next_in && armed_ff && sym.valid && !sym.sync;

	// A capture disarms, even on the cycle that take-next rises; otherwise a
	// sync or a fresh take-next edge rearms. If the edge won, the slice would
	// stay armed after its catch and take a second byte.
	assign nxt_armed = capture_pulse ? 1'b0 :
	                   (sync_seen || take_rise) ? 1'b1 : armed_ff;
	// Sync or a low take-next drops capture-done, so the low ripples on.
	assign nxt_done  = (sync_seen || !take_next_in) ? 1'b0 :
	                   capture_pulse ? 1'b1 : capture_done_out;

	// Chain state: arming, capture-done and the input latch.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			armed_ff         <= 1'b1;
			take_d_ff        <= 1'b0;
			capture_done_out <= 1'b0;
			in_ff            <= 8'h00;
		end else begin
			armed_ff         <= nxt_armed;
			take_d_ff        <= take_next_in;
			capture_done_out <= nxt_done;
			if (capture_pulse) begin
				in_ff <= sym.data;
			end
		end
	end

	// Two latch stages so every slice presents its byte on the same edge.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dec_ff               <= 8'h00;
			stage_ff             <= 1'b0;
			byte_out             <= 8'h00;
			rx_data_valid_strobe <= 1'b0;
		end else begin
			stage_ff             <= xfer;
			rx_data_valid_strobe <= stage_ff;
			if (xfer) begin
				dec_ff <= in_ff;
			end
			if (stage_ff) begin
				byte_out <= dec_ff;
			end
		end
	end

	// A caught byte stays held until the next rearm.
	property p_slice_hold;
		@(posedge clk) disable iff (sys_rst)
		(!armed_ff && !sync_seen && !take_rise) |=> $stable(in_ff);
	endproperty
	a_slice_hold: assert property (p_slice_hold) else $error("held byte changed");

endmodule

/* File: rtl/cwbm_rx_cascade.sv */
// Purpose: Cascade of receivers sharing one serial input, demultiplexing words.
// Assumes: Decoded symbols arrive on clk; mode pins are asynchronous.
// Notes:   The primary slice's take-next comes from a pin or the auto-repeat loop.
`timescale 1ns/1ps

// What this block does
// - Word bytes arrive one after another, one link
// - Receivers share input; done-to-take chain picks byte
// - Take-next tied high makes primary, starts chain
// - Link never faster than one byte time
// - Sync realigns chain to first receiver
// - Armed receiver catches next byte, then holds
// - Sync drops capture-done, low ripples down chain
// - All strobes rise together two cycles after sync
module cwbm_rx_cascade (
	input  wire logic                                   clk,
	input  wire logic                                   sys_rst,
	input  wire cwbm_pkg::cwbm_sym_t                    serial_in_pair,
	input  wire logic                                   primary_take_pin,
	input  wire logic                                   auto_repeat_pin,
	output logic [`CWBM_NUM_RX-1:0]                     capture_done_out,
	output logic [`CWBM_NUM_RX*`CWBM_BYTE_W-1:0]        rx_word,
	output logic [`CWBM_NUM_RX-1:0]                     rx_data_valid_strobe,
	output logic                                        rate_refused
);
	import cwbm_pkg::*;

	localparam int NRX = `CWBM_NUM_RX; // Slices in the chain.

	// Pin synchronisers; the first stage feeds only the second.
	logic                      prim_m_ff;   // Primary take pin, first stage.
	logic                      prim_s_ff;   // Primary take pin, settled.
	logic                      auto_m_ff;   // Auto-repeat pin, first stage.
	logic                      auto_s_ff;   // Auto-repeat pin, settled.
	logic [`CWBM_GAP_W-1:0]    gap_ff;      // Cycles left before next byte.
	logic [`CWBM_GAP_W-1:0]    nxt_gap;     // Next spacing count.
	logic                      last_d_ff;   // Last slice done, delayed.
	wire                       sym_acc;     // Symbol accepted this cycle.
	wire                       sync_acc;    // Accepted symbol is a sync.
	wire                       word_full;   // Last slice just caught its byte.
	wire                       xfer;        // Move caught bytes to outputs.
	wire  [NRX-1:0]            take_vec;    // Take-next seen by each slice.
	wire  [NRX-1:0]            cap_vec;     // Capture pulse of each slice.
	cwbm_sym_t                 sym_ok;      // Rate-limited shared symbol.

	// Symbols closer than one byte time are refused, not buffered.
	assign sym_acc  = serial_in_pair.valid && (gap_ff == 3'h0);
	assign sync_acc = sym_acc && serial_in_pair.sync;
	assign nxt_gap  = sym_acc ? 3'(`CWBM_BYTE_CYC - 1) :
	                  (gap_ff != 3'h0) ? gap_ff - 3'h1 : gap_ff;
	assign sym_ok   = '{valid: sym_acc, sync: serial_in_pair.sync,
	                    data: serial_in_pair.data};

	// Auto-repeat closes the loop with the inverted last done level.
	assign take_vec[0] = auto_s_ff ? !capture_done_out[NRX-1] : prim_s_ff;
	assign word_full   = capture_done_out[NRX-1] && !last_d_ff;
	// Words move out on a sync, or on a full chain in auto-repeat.
	assign xfer        = sync_acc || (auto_s_ff && word_full);

	// Synchronise the mode pins before any logic sees them.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prim_m_ff <= 1'b0;
			prim_s_ff <= 1'b0;
			auto_m_ff <= 1'b0;
			auto_s_ff <= 1'b0;
		end else begin
			prim_m_ff <= primary_take_pin;
			prim_s_ff <= prim_m_ff;
			auto_m_ff <= auto_repeat_pin;
			auto_s_ff <= auto_m_ff;
		end
	end

	// Byte spacing counter and the refused-symbol flag.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gap_ff       <= 3'h0;
			last_d_ff    <= 1'b0;
			rate_refused <= 1'b0;
		end else begin
			gap_ff       <= nxt_gap;
			last_d_ff    <= capture_done_out[NRX-1];
			rate_refused <= serial_in_pair.valid && !sym_acc;
		end
	end

	// Each slice after the first takes its upstream neighbour's capture-done as take-next.
	genvar gi;
	generate
		for (gi = 0; gi < NRX; gi++) begin : g_rx
			if (gi > 0) begin : g_link
				assign take_vec[gi] = capture_done_out[gi-1];
			end
			// All slices see the same symbol on the same cycle.
			cwbm_rx_slice u_slice (
				.clk                  (clk),
				.sys_rst              (sys_rst),
				.sym                  (sym_ok),
				.take_next_in         (take_vec[gi]),
				.xfer                 (xfer),
				.capture_done_out     (capture_done_out[gi]),
				.byte_out             (rx_word[(NRX-1-gi)*`CWBM_BYTE_W +: `CWBM_BYTE_W]),
				.rx_data_valid_strobe (rx_data_valid_strobe[gi]),
				.capture_pulse        (cap_vec[gi])
			);
		end
	endgenerate

	// At most one slice takes any byte.
	property p_one_taker;
		@(posedge clk) disable iff (sys_rst)
		$onehot0(cap_vec);
	endproperty
	a_one_taker: assert property (p_one_taker) else $error("byte taken twice");

	// Accepted symbols are spaced by at least five cycles.
	property p_rate;
		@(posedge clk) disable iff (sys_rst)
		sym_acc |=> !sym_acc [*4];
	endproperty
	a_rate: assert property (p_rate) else $error("byte rate exceeded");

	// A primary with an empty chain catches the next data byte.
	property p_primary;
		@(posedge clk) disable iff (sys_rst)
		(!auto_s_ff && prim_s_ff && $stable(prim_s_ff) && sym_acc && !serial_in_pair.sync
		 && capture_done_out == 4'h0) |=> capture_done_out[0];
	endproperty
	a_primary: assert property (p_primary) else $error("primary missed byte");

	// A sync clears every capture-done on the next edge.
	property p_realign;
		@(posedge clk) disable iff (sys_rst)
		sync_acc |=> (capture_done_out == 4'h0);
	endproperty
	a_realign: assert property (p_realign) else $error("sync did not realign");

	// Bytes fill in order: a slice fills only behind a full neighbour.
	property p_order;
		@(posedge clk) disable iff (sys_rst)
		$rose(capture_done_out[1]) |-> capture_done_out[0];
	endproperty
	a_order: assert property (p_order) else $error("bytes out of order");

	// A low capture-done upstream pulls the next one low.
	property p_ripple;
		@(posedge clk) disable iff (sys_rst)
		!capture_done_out[0] |=> !capture_done_out[1];
	endproperty
	a_ripple: assert property (p_ripple) else $error("low did not ripple");

	// All strobes rise together two edges after the transfer.
	property p_strobe;
		@(posedge clk) disable iff (sys_rst)
		xfer |-> ##2 (rx_data_valid_strobe == 4'hf);
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobes late or split");

	// A full slice ignores bytes until rearmed.
	property p_hold;
		@(posedge clk) disable iff (sys_rst)
		(capture_done_out[0] && take_vec[0] && !sync_acc) |-> !cap_vec[0];
	endproperty
	a_hold: assert property (p_hold) else $error("full slice took byte");

	// The low level moves on from the second slice to the third.
	property p_ripple_mid;
		@(posedge clk) disable iff (sys_rst)
		!capture_done_out[1] |=> !capture_done_out[2];
	endproperty
	a_ripple_mid: assert property (p_ripple_mid) else $error("low stuck at third slice");

	// And from the third slice on to the last one.
	property p_ripple_end;
		@(posedge clk) disable iff (sys_rst)
		!capture_done_out[2] |=> !capture_done_out[3];
	endproperty
	a_ripple_end: assert property (p_ripple_end) else $error("low stuck at last slice");

	// In auto-repeat a full chain pulls the primary's capture-done low next edge.
	property p_auto_drop;
		@(posedge clk) disable iff (sys_rst)
		(auto_s_ff && capture_done_out[NRX-1]) |=> !capture_done_out[0];
	endproperty
	a_auto_drop: assert property (p_auto_drop) else $error("auto-repeat loop stuck");

	// A symbol inside the spacing window is flagged on the next edge.
	property p_refused;
		@(posedge clk) disable iff (sys_rst)
		(serial_in_pair.valid && !sym_acc) |=> rate_refused;
	endproperty
	a_refused: assert property (p_refused) else $error("refused symbol not flagged");

	// The strobes are a single-cycle pulse.
	property p_strobe_pulse;
		@(posedge clk) disable iff (sys_rst)
		rx_data_valid_strobe[0] |=> !rx_data_valid_strobe[0];
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");

	// All strobes move as one; a split strobe would present a torn word.
	property p_strobe_all;
		@(posedge clk) disable iff (sys_rst)
		(rx_data_valid_strobe == 4'h0) || (rx_data_valid_strobe == 4'hf);
	endproperty
	a_strobe_all: assert property (p_strobe_all) else $error("strobes split");

	// Without a transfer the presented word stays put.
	property p_word_held;
		@(posedge clk) disable iff (sys_rst)
		!xfer |-> ##2 $stable(rx_word);
	endproperty
	a_word_held: assert property (p_word_held) else $error("word changed unasked");

endmodule

/* File: testbench/cwbm_tx_model.sv */
// Purpose: Far-side transmit controller that sends one word as byte symbols.
// Assumes: Word, load and sync choice come from the bench on clk.
// Notes:   Symbols change on the falling edge, so each spans one rising edge.
`timescale 1ns/1ps

module cwbm_tx_model (
	input  wire logic            clk,
	input  wire logic            word_load,
	input  wire logic [31:0]     word,
	input  wire logic            add_sync,
	input  wire logic            rearm,
	output cwbm_pkg::cwbm_sym_t  sym,
	output logic                 word_done_with_sync,
	output logic                 word_done_no_sync
);
	import cwbm_pkg::*;
	logic [4:0]  token_n_ff = 5'h1f; // One low bit marks the active stage.
	logic [2:0]  gap_ff     = 3'h0;  // Cycles left before the link takes another symbol.
	logic [31:0] hold_ff;            // Byte registers, loaded together, top byte first.
	initial sym = '0;
	assign word_done_no_sync   = ~token_n_ff[3];
	assign word_done_with_sync = ~token_n_ff[4];
	// Falling edge keeps select changes inside the low clock phase.
	always @(negedge clk) begin
		sym.valid <= 1'b0;
		sym.data  <= ~sym.data; // Idle data keeps moving so no stale byte lingers.
		if (gap_ff != 3'h0) begin
			gap_ff <= gap_ff - 3'h1;
		end else if (token_n_ff != 5'h1f) begin
			// Shifting in a one keeps a single low token alive.
			token_n_ff <= {token_n_ff[3:0], 1'b1};
			gap_ff     <= 3'h4;
			if (!token_n_ff[4]) begin
				sym.valid <= add_sync;
				sym.sync  <= 1'b1;
				// Acknowledge fed back as the load: the next word starts at once.
				if (rearm && word_done_with_sync) begin
					token_n_ff <= 5'h1e;
					hold_ff    <= word;
				end
			end else begin
				sym.valid <= 1'b1;
				sym.sync  <= 1'b0;
				sym.data  <= hold_ff[31:24];
				hold_ff   <= {hold_ff[23:0], 8'h00};
			end
		end
		// A load restarts the token but never shortens the link spacing.
		if (word_load) begin
			token_n_ff <= 5'h1e;
			hold_ff    <= word;
		end
	end
endmodule

/* File: testbench/cwbm_rx_cascade_bench.sv */
// Purpose: Self-checking bench for the receiver cascade.
// Assumes: The transmit model feeds symbols unless the bench takes the input over.
// Notes:   Inputs change 1 ns after the rising edge; outputs are read then too.
`timescale 1ns/1ps

module cwbm_rx_cascade_bench;
	import cwbm_pkg::*;
	logic        clk;              // 50 MHz clock.
	logic        sys_rst;          // Synchronous reset.
	logic        primary_take_pin; // Take-next of the primary slice.
	logic        auto_repeat_pin;  // Auto-repeat mode.
	logic        word_load;        // Load pulse for the transmit model.
	logic [31:0] word;             // Word handed to the model.
	logic        add_sync;         // Model sends a sync after the word.
	logic        rearm;            // Model reloads itself from its acknowledge.
	logic        use_tb;           // Bench drives the symbol input itself.
	cwbm_sym_t   sym_tb;           // Bench-made symbol.
	cwbm_sym_t   sym_model;        // Model-made symbol.
	cwbm_sym_t   serial_in_pair;   // Symbol seen by the design.
	logic [3:0]  capture_done_out; // Chain state.
	logic [31:0] rx_word;          // Presented word.
	logic [3:0]  rx_data_valid_strobe;
	logic        rate_refused;
	int          bad_count;
	int          checked;
	assign serial_in_pair = use_tb ? sym_tb : sym_model;
	cwbm_tx_model i_tx (.clk(clk), .word_load(word_load), .word(word), .add_sync(add_sync),
		.rearm(rearm), .sym(sym_model), .word_done_with_sync(), .word_done_no_sync());
	cwbm_rx_cascade i_dut (.clk(clk), .sys_rst(sys_rst), .serial_in_pair(serial_in_pair),
		.primary_take_pin(primary_take_pin), .auto_repeat_pin(auto_repeat_pin),
		.capture_done_out(capture_done_out), .rx_word(rx_word),
		.rx_data_valid_strobe(rx_data_valid_strobe), .rate_refused(rate_refused));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic send(input logic [31:0] w, input logic s);
		word      = w;
		add_sync  = s;
		word_load = 1'b1;
		tick(1);
		word_load = 1'b0;
	endtask
	// Waits, bounded, until a symbol of the given kind was taken at the last edge.
	// It always steps one edge first, so a symbol already seen is not counted twice.
	task automatic wait_sym(input logic s);
		int n;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (!(serial_in_pair.valid === 1'b1 && serial_in_pair.sync === s) && n < 40);
		chk(32'(n < 40), 32'h0000_0001);
	endtask
	// A symbol four cycles after an accepted one is dropped and flagged.
	task automatic t_rate;
		use_tb = 1'b1;
		sym_tb = {1'b1, 1'b0, 8'h3c};
		tick(1);
		sym_tb = {1'b0, 1'b0, 8'hc3};
		tick(3);
		sym_tb = {1'b1, 1'b0, 8'h5a};
		tick(1);
		sym_tb = {1'b0, 1'b0, 8'ha5};
		chk({31'h0000_0000, rate_refused}, 32'h0000_0001);
		chk({28'h000_0000, capture_done_out}, 32'h0000_0001);
		tick(1);
		chk({31'h0000_0000, rate_refused}, 32'h0000_0000);
		sym_tb = {1'b1, 1'b1, 8'h5a};
		tick(1);
		sym_tb = {1'b0, 1'b0, 8'ha5};
		chk({28'h000_0000, capture_done_out}, 32'h0000_0000);
		tick(1);
		chk({28'h000_0000, rx_data_valid_strobe}, 32'h0000_000f);
		chk(rx_word, 32'h3c00_0000);
		use_tb = 1'b0;
		tick(5);
	endtask
	// Bytes fill the chain in order; a sync presents the word.
	task automatic t_word(input logic [31:0] w);
		send(w, 1'b1);
		for (int k = 0; k < 4; k++) begin
			wait_sym(1'b0);
			tick(1);
			chk({28'h000_0000, capture_done_out}, (32'h0000_0001 << (k + 1)) - 32'h0000_0001);
		end
		wait_sym(1'b1);
		chk({28'h000_0000, capture_done_out}, 32'h0000_0000);
		tick(1);
		chk({28'h000_0000, rx_data_valid_strobe}, 32'h0000_000f);
		chk(rx_word, w);
		tick(1);
		chk({28'h000_0000, rx_data_valid_strobe}, 32'h0000_0000);
	endtask
	// Bytes past a full chain, or with the primary take pin low, are not caught.
	task automatic t_lost(input logic [31:0] w1, input logic [31:0] w2, input logic prim);
		primary_take_pin = prim;
		tick(3);
		send(w1, ~prim);
		repeat (4) wait_sym(1'b0);
		tick(6);
		chk({28'h000_0000, capture_done_out}, prim ? 32'h0000_000f : 32'h0000_0000);
		if (prim) begin
			send(w2, 1'b1);
			repeat (4) wait_sym(1'b0);
			wait_sym(1'b1);
			tick(2);
			chk(rx_word, w1);
		end
		primary_take_pin = 1'b1;
		tick(8);
	endtask
	// Auto-repeat: the last capture hands the word over and the chain rearms.
	// The model reloads from its acknowledge, so the second word follows unasked.
	task automatic t_auto(input logic [31:0] w);
		auto_repeat_pin = 1'b1;
		rearm           = 1'b1;
		tick(3);
		send(w, 1'b0);
		word = w ^ 32'h0000_0001;
		for (int j = 0; j < 2; j++) begin
			repeat (4) wait_sym(1'b0);
			tick(1);
			chk({31'h0000_0000, capture_done_out[3]}, 32'h0000_0001);
			tick(1);
			chk({28'h000_0000, rx_data_valid_strobe}, 32'h0000_000f);
			chk(rx_word, w ^ 32'(j));
			tick(6);
			chk({28'h000_0000, capture_done_out}, 32'h0000_0000);
			rearm = 1'b0;
		end
		auto_repeat_pin = 1'b0;
		tick(3);
	endtask
	initial begin
		bad_count        = 0;
		checked          = 0;
		sys_rst          = 1'b1;
		primary_take_pin = 1'b1;
		auto_repeat_pin  = 1'b0;
		word_load        = 1'b0;
		word             = 32'h0000_0000;
		add_sync         = 1'b0;
		rearm            = 1'b0;
		use_tb           = 1'b0;
		sym_tb           = {1'b0, 1'b0, 8'h55};
		tick(4);
		sys_rst = 1'b0;
		tick(3);
		t_rate;
		t_word(32'h1234_5678);
		t_lost(32'h9abc_def0, 32'h0f1e_2d3c, 1'b1);
		t_word(32'ha1b2_c3d4);
		t_lost(32'h7788_99aa, 32'h0000_0000, 1'b0);
		t_auto(32'hcafe_0123);
		test_done;
	end
	// Cuts a hang short; the whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		test_done;
	end
endmodule
